// *** hdl/tes_apb_slave.sv ***
// apb slave handshake: no wait states, registered read data and error
`timescale 1ns/1ps
module tes_apb_slave (
  input  wire logic                     ref_clk_in,
  input  wire logic                     rst_b_in,
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic                     hit_in,
  input  wire logic [tes_pkg::TES_DW-1:0] rdata_in,
  output logic                          pready_out,
  output logic                          pslverr_out,
  output logic      [tes_pkg::TES_DW-1:0] prdata_out,
  output logic                          wr_go_out,
  output logic                          rd_go_out
);

  logic                         pready_r;
  logic                         pslverr_r;
  logic [tes_pkg::TES_DW-1:0]   prdata_r;
  logic                         setup_w;
  logic                         done_w;

  // ready rises in the access phase, data is sampled at setup
  assign setup_w     = psel_in & ~penable_in;
  assign done_w      = psel_in & penable_in & pready_r;
  assign wr_go_out   = done_w & pwrite_in & hit_in;
  assign rd_go_out   = done_w & ~pwrite_in & hit_in;
  assign pready_out  = pready_r;
  assign pslverr_out = pslverr_r;
  assign prdata_out  = prdata_r;

  // handshake and read data registers
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= tes_pkg::TES_RST_32;
    end else begin
      pready_r  <= setup_w;
      pslverr_r <= setup_w & ~hit_in;
      if (setup_w) begin
        prdata_r <= (hit_in && !pwrite_in) ? rdata_in : tes_pkg::TES_RST_32;
      end
    end
  end

endmodule // tes_apb_slave

// *** hdl/tes_event_status.sv ***
// timer event generation, status flags and interrupt/dma request logic
//
// Notes on behaviour
// - compare match sets channel 1 flag in output mode, not center-aligned.
// - capture sets channel 1 flag; software clear or capture read clears it.
// - update event sets update flag bit 0, except a software update with source one; only software writing zero clears.
// - repetition overflow or underflow makes an update event unless updates disabled.
// - software update bit makes update event and sets flag when source zero.
// - brake bit 7 written one: output enable off, brake flag, irq and dma.
// - trigger bit 6 written one sets trigger flag, requests, then self-clears.
`timescale 1ns/1ps
module tes_event_status (
  input  wire logic                       ref_clk_in,
  input  wire logic                       rst_b_in,
  input  wire logic                       psel_in,
  input  wire logic                       penable_in,
  input  wire logic                       pwrite_in,
  input  wire logic [tes_pkg::TES_AW-1:0] paddr_in,
  input  wire logic [tes_pkg::TES_DW-1:0] pwdata_in,
  output logic      [tes_pkg::TES_DW-1:0] prdata_out,
  output logic                            pready_out,
  output logic                            pslverr_out,
  input  wire logic                       rep_overflow_in,
  input  wire logic                       cmp_match_in,
  input  wire logic                       capture_event_in,
  input  wire logic [tes_pkg::TES_RW-1:0] capture_value_in,
  output logic                            main_output_enable_out,
  output logic                            update_event_out,
  output logic                            trigger_event_out,
  output logic                            brake_event_out,
  output logic      [tes_pkg::TES_RW-1:0] dma_req_out,
  output logic                            irq_out
);

  // ***************************************************************
  // declarations
  // ***************************************************************
  logic [tes_pkg::TES_RW-1:0] ctrl_r;
  logic [tes_pkg::TES_RW-1:0] ctrl_nxt;
  logic [tes_pkg::TES_RW-1:0] dma_en_r;
  logic [tes_pkg::TES_RW-1:0] irq_mask_r;
  logic [tes_pkg::TES_RW-1:0] evgen_r;
  logic [tes_pkg::TES_RW-1:0] evgen_nxt;
  logic [tes_pkg::TES_RW-1:0] capt_r;
  logic                       upd_evt_r;
  logic                       trg_evt_r;
  logic                       brk_evt_r;
  logic [tes_pkg::TES_RW-1:0] dma_req_r;
  logic                       irq_r;
  logic [tes_pkg::TES_RW-1:0] flags_w;
  logic [tes_pkg::TES_RW-1:0] stat_w;
  logic [tes_pkg::TES_DW-1:0] rdata_w;
  logic [tes_pkg::TES_DW-1:0] prdata_w;
  logic [tes_pkg::TES_RW-1:0] wdata16_w;
  logic                       wr_go_w;
  logic                       rd_go_w;
  logic                       sel_ctrl_w;
  logic                       sel_dma_w;
  logic                       sel_flags_w;
  logic                       sel_evgen_w;
  logic                       sel_capt_w;
  logic                       sel_stat_w;
  logic                       sel_mask_w;
  logic                       hit_w;
  logic                       upd_dis_w;
  logic                       upd_src_w;
  logic                       ch1_in_w;
  logic                       center_w;
  logic                       wr_ug_w;
  logic                       wr_tg_w;
  logic                       wr_bg_w;
  tes_pkg::tes_evt_t          evt_w;
  tes_pkg::tes_evt_t          flag_set_w;
  logic [tes_pkg::TES_RW-1:0] evt_bits_w;
  logic [tes_pkg::TES_RW-1:0] flag_set_bits_w;
  logic [tes_pkg::TES_RW-1:0] flag_clr_w;
  logic [tes_pkg::TES_RW-1:0] stat_clr_w;

  // ***************************************************************
  // bus decode
  // ***************************************************************
  // selects from the live address, valid through setup and access
  assign sel_ctrl_w  = tes_pkg::tes_sel(paddr_in, tes_pkg::TES_OFS_CTRL);
  assign sel_dma_w   = tes_pkg::tes_sel(paddr_in, tes_pkg::TES_OFS_DMA_EN);
  assign sel_flags_w = tes_pkg::tes_sel(paddr_in, tes_pkg::TES_OFS_FLAGS);
  assign sel_evgen_w = tes_pkg::tes_sel(paddr_in, tes_pkg::TES_OFS_EVGEN);
  assign sel_capt_w  = tes_pkg::tes_sel(paddr_in, tes_pkg::TES_OFS_CAPT);
  assign sel_stat_w  = tes_pkg::tes_sel(paddr_in, tes_pkg::TES_OFS_IRQ_STAT);
  assign sel_mask_w  = tes_pkg::tes_sel(paddr_in, tes_pkg::TES_OFS_IRQ_MASK);
  assign hit_w       = sel_ctrl_w | sel_dma_w | sel_flags_w | sel_evgen_w
                     | sel_capt_w | sel_stat_w | sel_mask_w;
  assign wdata16_w   = pwdata_in[tes_pkg::TES_RW-1:0];

  // read mux, upper half of every word reads zero
  // reserved event bits read zero
  assign rdata_w = {16'h0000,
                    sel_ctrl_w  ? ctrl_r :
                    sel_dma_w   ? dma_en_r :
                    sel_flags_w ? flags_w :
                    sel_evgen_w ? (evgen_r & tes_pkg::TES_EVGEN_MASK) :
                    sel_capt_w  ? capt_r :
                    sel_stat_w  ? stat_w :
                    sel_mask_w  ? irq_mask_r : tes_pkg::TES_RST_16};

  tes_apb_slave u_apb (
    .ref_clk_in  (ref_clk_in),
    .rst_b_in    (rst_b_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .hit_in      (hit_w),
    .rdata_in    (rdata_w),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .prdata_out  (prdata_w),
    .wr_go_out   (wr_go_w),
    .rd_go_out   (rd_go_w)
  );
  assign prdata_out = prdata_w;

  // ***************************************************************
  // event sources
  // ***************************************************************
  assign upd_dis_w = ctrl_r[tes_pkg::TES_CTL_UPD_DIS];
  assign upd_src_w = ctrl_r[tes_pkg::TES_CTL_UPD_SRC];
  assign ch1_in_w  = ctrl_r[tes_pkg::TES_CTL_CH1_IN];
  assign center_w  = ctrl_r[tes_pkg::TES_CTL_CENTER];
  // a zero written to any event bit is simply no event
  assign wr_ug_w   = wr_go_w & sel_evgen_w & wdata16_w[tes_pkg::TES_BIT_UPD];
  assign wr_tg_w   = wr_go_w & sel_evgen_w & wdata16_w[tes_pkg::TES_BIT_TRG];
  assign wr_bg_w   = wr_go_w & sel_evgen_w & wdata16_w[tes_pkg::TES_BIT_BRK];

  assign evt_w.update = ~upd_dis_w & (rep_overflow_in | wr_ug_w);
  assign evt_w.cc1    = ch1_in_w ? capture_event_in : (cmp_match_in & ~center_w);
  assign evt_w.trigger = wr_tg_w;
  assign evt_w.brake   = wr_bg_w;

  // software update flags only with source zero
  assign flag_set_w.update  = ~upd_dis_w & (rep_overflow_in | (wr_ug_w & ~upd_src_w));
  assign flag_set_w.cc1     = evt_w.cc1;
  assign flag_set_w.trigger = evt_w.trigger;
  assign flag_set_w.brake   = evt_w.brake;
  assign evt_bits_w         = tes_pkg::tes_evt_bits(flag_set_w);
  assign flag_set_bits_w    = evt_bits_w;

  // ***************************************************************
  // flags and interrupt status
  // ***************************************************************
  // write zero clears, write one keeps
  // capture read clears channel 1 flag in input mode
  assign flag_clr_w = ((wr_go_w & sel_flags_w) ? (~wdata16_w & tes_pkg::TES_FLAG_MASK)
                                               : tes_pkg::TES_RST_16)
                    | ((rd_go_w & sel_capt_w & ch1_in_w) ?
                       tes_pkg::tes_evt_bits('{brake: 1'b0, trigger: 1'b0, cc1: 1'b1,
                                               update: 1'b0}) : tes_pkg::TES_RST_16);

  tes_sticky_flags #(.W(tes_pkg::TES_RW)) u_flags (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .set_in     (flag_set_bits_w),
    .clr_in     (flag_clr_w),
    .flags_out  (flags_w)
  );

  // read clears only what the read returned, so a late event survives
  assign stat_clr_w = (rd_go_w & sel_stat_w) ? prdata_w[tes_pkg::TES_RW-1:0]
                                            : tes_pkg::TES_RST_16;

  tes_sticky_flags #(.W(tes_pkg::TES_RW)) u_stat (
    .ref_clk_in (ref_clk_in),
    .rst_b_in   (rst_b_in),
    .set_in     (evt_bits_w),
    .clr_in     (stat_clr_w),
    .flags_out  (stat_w)
  );

  // ***************************************************************
  // software registers
  // ***************************************************************
  // brake beats a software set of the output enable in the same cycle
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_go_w && sel_ctrl_w) begin
      ctrl_nxt = wdata16_w & tes_pkg::TES_CTRL_MASK;
    end
    if (evt_w.brake) begin
      ctrl_nxt[tes_pkg::TES_CTL_MOE] = 1'b0;
    end
  end

  // brake bit held until software clears
  always_comb begin
    evgen_nxt = evgen_r;
    evgen_nxt[tes_pkg::TES_BIT_TRG] = 1'b0;
    evgen_nxt[tes_pkg::TES_BIT_UPD] = 1'b0;
    if (wr_go_w && sel_evgen_w) begin
      evgen_nxt = wdata16_w & tes_pkg::TES_EVGEN_MASK;
    end
  end

  // register bank
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      ctrl_r     <= tes_pkg::TES_RST_16;
      dma_en_r   <= tes_pkg::TES_RST_16;
      irq_mask_r <= tes_pkg::TES_RST_16;
      evgen_r    <= tes_pkg::TES_RST_16;
    end else begin
      ctrl_r  <= ctrl_nxt;
      evgen_r <= evgen_nxt;
      if (wr_go_w && sel_dma_w) begin
        dma_en_r <= wdata16_w & tes_pkg::TES_FLAG_MASK;
      end
      if (wr_go_w && sel_mask_w) begin
        irq_mask_r <= wdata16_w & tes_pkg::TES_FLAG_MASK;
      end
    end
  end

  // capture register latches the counter value on a capture event
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      capt_r <= tes_pkg::TES_RST_16;
    end else if (ch1_in_w && capture_event_in) begin
      capt_r <= capture_value_in;
    end
  end

  // ***************************************************************
  // outputs, all registered
  // ***************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      upd_evt_r <= 1'b0;
      trg_evt_r <= 1'b0;
      brk_evt_r <= 1'b0;
      dma_req_r <= tes_pkg::TES_RST_16;
      irq_r     <= 1'b0;
    end else begin
      upd_evt_r <= evt_w.update;
      trg_evt_r <= evt_w.trigger;
      brk_evt_r <= evt_w.brake;
      dma_req_r <= evt_bits_w & dma_en_r;
      // level interrupt lags status by one cycle
      irq_r     <= |(stat_w & irq_mask_r);
    end
  end

  assign main_output_enable_out = ctrl_r[tes_pkg::TES_CTL_MOE];
  assign update_event_out       = upd_evt_r;
  assign trigger_event_out      = trg_evt_r;
  assign brake_event_out        = brk_evt_r;
  assign dma_req_out            = dma_req_r;
  assign irq_out                = irq_r;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence evgen_wr_s(int b);
    wr_go_w && sel_evgen_w && wdata16_w[b];
  endsequence

  sequence upd_seen_s;
    update_event_out && flags_w[tes_pkg::TES_BIT_UPD];
  endsequence

  cmp_flag_set_a: assert property (
    cmp_match_in && !ch1_in_w && !center_w |=> flags_w[tes_pkg::TES_BIT_CC1])
    else $error("compare match did not set channel 1 flag");

  center_no_set_a: assert property (
    !flags_w[tes_pkg::TES_BIT_CC1] && !ch1_in_w && center_w
    |=> !flags_w[tes_pkg::TES_BIT_CC1])
    else $error("channel 1 flag set in center-aligned mode");

  capt_flag_set_a: assert property (
    ch1_in_w && capture_event_in
    |=> flags_w[tes_pkg::TES_BIT_CC1] && capt_r == $past(capture_value_in))
    else $error("capture did not set flag or latch value");

  capt_read_clr_a: assert property (
    rd_go_w && sel_capt_w && ch1_in_w && !capture_event_in
    |=> !flags_w[tes_pkg::TES_BIT_CC1])
    else $error("capture read did not clear channel 1 flag");

  upd_flag_hold_a: assert property (
    flags_w[tes_pkg::TES_BIT_UPD]
    && !(wr_go_w && sel_flags_w && !wdata16_w[tes_pkg::TES_BIT_UPD])
    |=> flags_w[tes_pkg::TES_BIT_UPD])
    else $error("update flag dropped without software clear");

  rep_update_a: assert property (
    rep_overflow_in && !upd_dis_w |=> upd_seen_s)
    else $error("repetition wrap gave no update event");

  sw_update_a: assert property (
    evgen_wr_s(tes_pkg::TES_BIT_UPD) ##0 (!upd_dis_w && !upd_src_w) |=> upd_seen_s)
    else $error("software update gave no update event");

  brake_a: assert property (
    evgen_wr_s(tes_pkg::TES_BIT_BRK)
    |=> !main_output_enable_out && flags_w[tes_pkg::TES_BIT_BRK] && brake_event_out)
    else $error("brake write did not brake");

  brake_hold_a: assert property (
    evgen_r[tes_pkg::TES_BIT_BRK] && !(wr_go_w && sel_evgen_w)
    |=> evgen_r[tes_pkg::TES_BIT_BRK])
    else $error("brake bit cleared by hardware");

  trig_a: assert property (
    evgen_wr_s(tes_pkg::TES_BIT_TRG)
    |=> trigger_event_out && flags_w[tes_pkg::TES_BIT_TRG]
        ##1 !evgen_r[tes_pkg::TES_BIT_TRG])
    else $error("trigger write failed or bit did not self-clear");

  evgen_resv_a: assert property (
    wr_go_w && sel_evgen_w |=> evgen_r[15:8] == 8'h00)
    else $error("reserved event generation bits stored");

endmodule // tes_event_status

// *** hdl/tes_pkg.sv ***
// shared constants, register map and event carrier for the timer event/status block
package tes_pkg;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int TES_AW = 8;
  localparam int TES_DW = 32;
  localparam int TES_RW = 16;

  // ***************************************************************
  // register byte offsets
  // ***************************************************************
  localparam logic [TES_AW-1:0] TES_OFS_CTRL     = 8'h00;
  localparam logic [TES_AW-1:0] TES_OFS_DMA_EN   = 8'h0c;
  localparam logic [TES_AW-1:0] TES_OFS_FLAGS    = 8'h10;
  localparam logic [TES_AW-1:0] TES_OFS_EVGEN    = 8'h14;
  localparam logic [TES_AW-1:0] TES_OFS_CAPT     = 8'h34;
  localparam logic [TES_AW-1:0] TES_OFS_IRQ_STAT = 8'h40;
  localparam logic [TES_AW-1:0] TES_OFS_IRQ_MASK = 8'h44;

  // ***************************************************************
  // field positions: flags, event bits and status share one layout
  // ***************************************************************
  localparam int TES_BIT_UPD = 0;
  localparam int TES_BIT_CC1 = 1;
  localparam int TES_BIT_TRG = 6;
  localparam int TES_BIT_BRK = 7;

  // control register fields
  localparam int TES_CTL_UPD_DIS = 0;
  localparam int TES_CTL_UPD_SRC = 1;
  localparam int TES_CTL_CH1_IN  = 2;
  localparam int TES_CTL_CENTER  = 3;
  localparam int TES_CTL_MOE     = 4;

  // implemented-bit masks and reset values
  localparam logic [TES_RW-1:0] TES_EVGEN_MASK = 16'h00c1;
  localparam logic [TES_RW-1:0] TES_FLAG_MASK  = 16'h00c3;
  localparam logic [TES_RW-1:0] TES_CTRL_MASK  = 16'h001f;
  localparam logic [TES_RW-1:0] TES_RST_16     = 16'h0000;
  localparam logic [TES_DW-1:0] TES_RST_32     = 32'h0000_0000;

  // one bit per event produced by the block
  typedef struct packed {
    logic brake;
    logic trigger;
    logic cc1;
    logic update;
  } tes_evt_t;

  // spread an event set onto the shared 16-bit layout
  function automatic logic [TES_RW-1:0] tes_evt_bits(input tes_evt_t e);
    logic [TES_RW-1:0] v;
    v = TES_RST_16;
    v[TES_BIT_UPD] = e.update;
    v[TES_BIT_CC1] = e.cc1;
    v[TES_BIT_TRG] = e.trigger;
    v[TES_BIT_BRK] = e.brake;
    return v;
  endfunction

  // address match, used by every register select
  function automatic logic tes_sel(input logic [TES_AW-1:0] a, input logic [TES_AW-1:0] o);
    return a == o;
  endfunction

endpackage

// *** hdl/tes_sticky_flags.sv ***
// sticky flag bank: hardware sets, a clear mask drops bits, set wins
`timescale 1ns/1ps
module tes_sticky_flags #(
  parameter int W = 16
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rst_b_in,
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  output logic      [W-1:0] flags_out
);

  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  // a set in the clearing cycle survives so no event is lost
  assign flags_nxt = (flags_r & ~clr_in) | set_in;
  assign flags_out = flags_r;

  // flag storage
  always_ff @(posedge ref_clk_in) begin
    if (!rst_b_in) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

endmodule // tes_sticky_flags

// *** testbench/tes_event_status_tb.sv ***
// self-checking bench for the timer event/status block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tes_event_status_tb;
  logic        ref_clk_in;
  logic        rst_b_in;
  logic        psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, d, v;
  logic        pready, pslverr, e, main_output_enable, upd_ev, trg_ev, brk_ev, irq;
  logic [2:0]  tin;
  logic [15:0] capv, dma;
  int          n_mismatch, compares;

  tes_event_status u_dut (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .rep_overflow_in(tin[0]),
    .cmp_match_in(tin[1]), .capture_event_in(tin[2]), .capture_value_in(capv),
    .main_output_enable_out(main_output_enable), .update_event_out(upd_ev), .trigger_event_out(trg_ev),
    .brake_event_out(brk_ev), .dma_req_out(dma), .irq_out(irq)
  );

  // ***************************************************************
  // clock, watchdog, helpers
  // ***************************************************************
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // far longer than the sequence needs, so only a hang trips it
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_mismatch++;
    report_and_stop;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // only the brake bit survives a write to the event register
  function automatic logic [31:0] exp_evgen(input logic [31:0] w);
    return w & 32'h0000_0080;
  endfunction

  task automatic report_and_stop;
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // one apb transfer: setup, then access held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge ref_clk_in);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    // no cycle limit here: a slave that never answers is left to the watchdog
    do begin
      @(posedge ref_clk_in);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input string nm);
    xfer(1'b0, a, 32'h0000_0000);
    `CHK(nm, x, d)
  endtask

  // one-cycle pulse on a timer input, returns just after the capturing edge
  task automatic pulse(input logic [2:0] m);
    @(posedge ref_clk_in);
    tin <= m;
    @(posedge ref_clk_in);
    tin <= 3'h0;
    #1;
  endtask

  task automatic settle;
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask

  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    n_mismatch = 0;
    compares = 0;
    rst_b_in = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tin = 3'h0;
    capv = 16'h0000;
    v = 32'h1341_5d8c;
    repeat (10) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    rdchk(tes_pkg::TES_OFS_EVGEN, 32'h0, "evgen_reset");
    rdchk(tes_pkg::TES_OFS_FLAGS, 32'h0, "flags_reset");
    `CHK("mapped_err", 1'b0, e)
    `CHK("moe_reset", 1'b0, main_output_enable)
    xfer(1'b0, 8'h7c, 32'h0);
    `CHK("unmapped_err", 1'b1, e)
    `CHK("unmapped_data", 32'h0, d)
    // overflow makes an update event, dma and irq follow
    wr(tes_pkg::TES_OFS_IRQ_MASK, 32'h1);
    wr(tes_pkg::TES_OFS_DMA_EN, 32'h1);
    pulse(3'h1);
    `CHK("upd_event", 1'b1, upd_ev)
    `CHK("upd_dma", 16'h0001, dma)
    @(posedge ref_clk_in);
    #1;
    `CHK("upd_irq", 1'b1, irq)
    rdchk(tes_pkg::TES_OFS_FLAGS, 32'h1, "uif_set");
    wr(tes_pkg::TES_OFS_FLAGS, 32'hffff);
    rdchk(tes_pkg::TES_OFS_FLAGS, 32'h1, "uif_write1_keeps");
    rdchk(tes_pkg::TES_OFS_IRQ_STAT, 32'h1, "stat_upd");
    settle;
    `CHK("irq_cleared", 1'b0, irq)
    wr(tes_pkg::TES_OFS_FLAGS, 32'h0);
    rdchk(tes_pkg::TES_OFS_FLAGS, 32'h0, "uif_write0");
    // update disabled blocks both sources
    wr(tes_pkg::TES_OFS_CTRL, 32'h1);
    pulse(3'h1);
    `CHK("upd_disabled", 1'b0, upd_ev)
    wr(tes_pkg::TES_OFS_EVGEN, 32'h1);
    rdchk(tes_pkg::TES_OFS_FLAGS, 32'h0, "ug_disabled");
    wr(tes_pkg::TES_OFS_CTRL, 32'h0);
    wr(tes_pkg::TES_OFS_EVGEN, 32'h1);
    rdchk(tes_pkg::TES_OFS_FLAGS, 32'h1, "ug_sets_uif");
    rdchk(tes_pkg::TES_OFS_EVGEN, 32'h0, "ug_selfclear");
    wr(tes_pkg::TES_OFS_FLAGS, 32'h0);
    wr(tes_pkg::TES_OFS_CTRL, 32'h2);
    wr(tes_pkg::TES_OFS_EVGEN, 32'h1);
    rdchk(tes_pkg::TES_OFS_FLAGS, 32'h0, "ug_source1");
    // compare match: edge mode sets, center mode does not
    wr(tes_pkg::TES_OFS_CTRL, 32'h0);
    pulse(3'h2);
    rdchk(tes_pkg::TES_OFS_FLAGS, 32'h2, "cmp_sets");
    rdchk(tes_pkg::TES_OFS_FLAGS, 32'h2, "cmp_sticky");
    wr(tes_pkg::TES_OFS_FLAGS, 32'h0);
    wr(tes_pkg::TES_OFS_CTRL, 32'h8);
    pulse(3'h2);
    rdchk(tes_pkg::TES_OFS_FLAGS, 32'h0, "cmp_center");
    // capture: random values, read of capture register clears
    wr(tes_pkg::TES_OFS_CTRL, 32'h4);
    for (int i = 0; i < 3; i++) begin
      v = lfsr(v);
      capv <= v[15:0];
      pulse(3'h4);
      rdchk(tes_pkg::TES_OFS_FLAGS, 32'h2, "cap_sets");
      rdchk(tes_pkg::TES_OFS_CAPT, {16'h0, v[15:0]}, "cap_value");
      rdchk(tes_pkg::TES_OFS_FLAGS, 32'h0, "cap_read_clr");
    end
    pulse(3'h2);
    pulse(3'h4);
    wr(tes_pkg::TES_OFS_FLAGS, 32'h0);
    rdchk(tes_pkg::TES_OFS_FLAGS, 32'h0, "cap_sw_clr");
    // brake: output enable drops, bit stays until written zero
    wr(tes_pkg::TES_OFS_IRQ_MASK, 32'h80);
    wr(tes_pkg::TES_OFS_DMA_EN, 32'hc0);
    wr(tes_pkg::TES_OFS_CTRL, 32'h10);
    settle;
    `CHK("moe_on", 1'b1, main_output_enable)
    wr(tes_pkg::TES_OFS_EVGEN, 32'h80);
    #1;
    `CHK("brake_event", 1'b1, brk_ev)
    `CHK("brake_dma", 16'h0080, dma)
    settle;
    `CHK("brake_moe", 1'b0, main_output_enable)
    `CHK("brake_irq", 1'b1, irq)
    rdchk(tes_pkg::TES_OFS_FLAGS, 32'h80, "brake_flag");
    rdchk(tes_pkg::TES_OFS_EVGEN, 32'h80, "bg_stays");
    wr(tes_pkg::TES_OFS_CTRL, 32'h10);
    wr(tes_pkg::TES_OFS_EVGEN, 32'h0);
    settle;
    `CHK("bg_zero_noop", 1'b1, main_output_enable)
    rdchk(tes_pkg::TES_OFS_EVGEN, 32'h0, "bg_cleared");
    // trigger with reserved bits set alongside
    wr(tes_pkg::TES_OFS_FLAGS, 32'h0);
    wr(tes_pkg::TES_OFS_EVGEN, 32'hffff_ff40);
    #1;
    `CHK("trig_event", 1'b1, trg_ev)
    `CHK("trig_dma", 16'h0040, dma)
    rdchk(tes_pkg::TES_OFS_FLAGS, 32'h40, "trig_flag");
    rdchk(tes_pkg::TES_OFS_EVGEN, exp_evgen(32'hffff_ff40), "tg_selfclear");
    // random event register writes: only the brake bit reads back
    for (int i = 0; i < 4; i++) begin
      v = lfsr(v);
      wr(tes_pkg::TES_OFS_EVGEN, v);
      rdchk(tes_pkg::TES_OFS_EVGEN, exp_evgen(v), "evgen_random");
    end
    report_and_stop;
  end
endmodule // tes_event_status_tb
